// >>> pkg/cfglk_pkg.sv
// Constants and carrier types for the configuration lock and phase-shed threshold bank.
// Assumes a single 20 MHz clock domain with a synchronous active-low reset.
package cfglk_pkg;

  localparam int LVL_CNT = 4;
  localparam int MAR_CNT = 3;
  localparam int CODE_CNT = 5;

  // Register offsets
  localparam logic [7:0] KEY_OFF = 8'h00;
  localparam logic [7:0] THR_OFF = 8'h01;
  localparam logic [7:0] MAR_OFF = 8'h05;
  localparam logic [7:0] LOCK_LO = 8'h01;
  localparam logic [7:0] LOCK_HI = 8'h5F;

  // Key value that locks the configuration range
  localparam logic [7:0] KEY_LOCK_VAL = 8'hA6;

  // Values after reset
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [LVL_CNT-1:0][7:0] THR_RST = {8'h60, 8'h40, 8'h20, 8'h10};
  localparam logic [2:0] MAR_RST = 3'h4;
  localparam logic [2:0] LVL4_MAR = 3'h4;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [3:0] PHASES_RST = 4'h1;

  // One threshold or margin step, in microvolts
  localparam int SHED_STEP_UV = 12500;

  // Bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_RD_BIT = 4'h7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_REG  = 7'h04,
    ST_WR   = 7'h08,
    ST_RD   = 7'h10,
    ST_ACK  = 7'h20,
    ST_RACK = 7'h40
  } cfglk_i2c_st_t;

  typedef struct packed {
    logic [7:0] thr;
    logic [2:0] margin;
  } cfglk_level_t;

  typedef struct packed {
    logic [8:0] upper;
    logic [7:0] lower;
  } cfglk_points_t;

  typedef cfglk_level_t [LVL_CNT-1:0] cfglk_cfg_t;
  typedef cfglk_points_t [LVL_CNT-1:0] cfglk_pts_t;
  typedef logic [CODE_CNT-1:0][2:0] cfglk_codes_t;

endpackage

// >>> hdl/cfglk_shed_points.sv
// Switching points of one shed level: threshold plus and minus its margin.
// Assumes threshold and margin share the same step; result registered once.
`timescale 1ns/10ps
module cfglk_shed_points #(
  parameter int LVL_IDX = 0
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire cfglk_pkg::cfglk_level_t cfg_i,
  output cfglk_pkg::cfglk_points_t pts_o
);
  import cfglk_pkg::*;

  cfglk_points_t pts_ff;
  cfglk_points_t nxt_pts;

  always_comb begin
    nxt_pts.upper = {1'b0, cfg_i.thr} + {6'h00, cfg_i.margin};
    // Clamp at zero so a small threshold never wraps to a huge lower point
    if (cfg_i.thr > {5'h00, cfg_i.margin}) begin
      nxt_pts.lower = cfg_i.thr - {5'h00, cfg_i.margin};
    end else begin
      nxt_pts.lower = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      // Each level resets to the points of its own default threshold
      pts_ff.upper <= {1'b0, THR_RST[LVL_IDX]} + {6'h00, MAR_RST};
      pts_ff.lower <= THR_RST[LVL_IDX] - {5'h00, MAR_RST};
    end else begin
      pts_ff <= nxt_pts;
    end
  end

  assign pts_o = pts_ff;

endmodule

// >>> hdl/cfglk_bank.sv
// Configuration bank: two-wire slave, write-lock key, shed thresholds and margins,
// and the load-level tracker that picks the active phase count.
// Assumes scl and sda are already synchronous to ref_clk_i and far slower than it.
//
// Functional notes
// - Incoming writes are acknowledged only while power good is high, else not-acknowledged.
// - Key register at 0x00, reset zero; value 0xA6 locks range 0x01 to 0x5F.
// - Configuration range updates only while key differs from 0xA6; host writes 0xA6 to protect.
// - Four 8-bit thresholds at 0x01-0x04, each step worth 12.5mV.
// - With pin strapping enabled, thresholds load from phase output straps, else fixed defaults.
// - Three-bit margins reset to 4; switching points are threshold plus and minus margin.
// - Threshold and margin writes need unlocked key and power state high or override.
// - Each load level's 3-bit code selects one to eight active phases linearly.
`timescale 1ns/10ps
module cfglk_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h20
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic power_good_i,
  input wire logic power_state_indicator_i,
  input wire logic psi_override_i,
  input wire logic pin_strap_setting_i,
  input wire logic [7:0] phase_output_two_strap_i,
  input wire logic [7:0] phase_output_three_strap_i,
  input wire logic [7:0] phase_output_five_strap_i,
  input wire logic [7:0] phase_output_seven_strap_i,
  input wire logic [7:0] load_sense_i,
  input wire cfglk_pkg::cfglk_codes_t phase_code_i,
  output cfglk_pkg::cfglk_cfg_t level_cfg_o,
  output cfglk_pkg::cfglk_pts_t shed_points_o,
  output logic lock_active_o,
  output logic [2:0] load_level_o,
  output logic [3:0] active_phases_o
);
  import cfglk_pkg::*;

  function automatic logic lvl_hit(input logic [7:0] addr, input logic [7:0] base,
                                   input int idx);
    lvl_hit = (addr == base + 8'(idx));
  endfunction

  // Bus side state
  cfglk_i2c_st_t st_ff, nxt_st, after_ff, nxt_after;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] sh_ff, nxt_sh;
  logic [7:0] ptr_ff, nxt_ptr;
  logic drv_ff, nxt_drv;
  logic nack_ff, nxt_nack;
  logic scl_q_ff, sda_q_ff;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic wr_stb;
  logic [7:0] rd_byte;

  // Register state
  logic [7:0] key_ff, nxt_key;
  logic [LVL_CNT-1:0][7:0] thr_ff, nxt_thr;
  logic [MAR_CNT-1:0][2:0] mar_ff, nxt_mar;
  logic strap_done_ff, nxt_strap_done;
  logic locked, cfg_wr_ok;

  // Level tracker state
  logic [2:0] lvl_ff, nxt_lvl;
  logic [3:0] phases_ff, nxt_phases;
  cfglk_pts_t pts;

  assign scl_rise = scl_i & ~scl_q_ff;
  assign scl_fall = ~scl_i & scl_q_ff;
  assign start_det = scl_i & scl_q_ff & sda_q_ff & ~sda_i;
  assign stop_det = scl_i & scl_q_ff & ~sda_q_ff & sda_i;

  assign locked = (key_ff == KEY_LOCK_VAL);
  assign cfg_wr_ok = ~locked & (power_state_indicator_i | psi_override_i);

  // Reads are never gated by the key or power state
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_ff == KEY_OFF) begin
      rd_byte = key_ff;
    end
    for (int i = 0; i < LVL_CNT; i++) begin
      if (lvl_hit(ptr_ff, THR_OFF, i)) begin
        rd_byte = thr_ff[i];
      end
    end
    for (int i = 0; i < MAR_CNT; i++) begin
      if (lvl_hit(ptr_ff, MAR_OFF, i)) begin
        rd_byte = {5'h00, mar_ff[i]};
      end
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_after = after_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_ptr = ptr_ff;
    nxt_drv = drv_ff;
    nxt_nack = nack_ff;
    wr_stb = 1'b0;
    if (start_det) begin
      nxt_st = ST_ADDR;
      nxt_cnt = 4'h0;
      nxt_drv = 1'b0;
    end else if (stop_det) begin
      nxt_st = ST_IDLE;
      nxt_drv = 1'b0;
    end else begin
      case (st_ff)
        ST_ADDR, ST_REG, ST_WR: begin
          if (scl_rise && cnt_ff != BITS_PER_BYTE) begin
            nxt_sh = {sh_ff[6:0], sda_i};
            nxt_cnt = cnt_ff + 4'h1;
          end else if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            nxt_cnt = 4'h0;
            if (st_ff == ST_ADDR) begin
              // A write header while power is not good is left unanswered
              if (sh_ff[7:1] == DEV_ADDR && (sh_ff[0] || power_good_i)) begin
                nxt_st = ST_ACK;
                nxt_drv = 1'b1;
                nxt_after = sh_ff[0] ? ST_RD : ST_REG;
              end else begin
                nxt_st = ST_IDLE;
              end
            end else if (!power_good_i) begin
              nxt_st = ST_IDLE;
            end else begin
              nxt_st = ST_ACK;
              nxt_drv = 1'b1;
              nxt_after = ST_WR;
              if (st_ff == ST_REG) begin
                nxt_ptr = sh_ff;
              end else begin
                wr_stb = 1'b1;
                nxt_ptr = ptr_ff + 8'h01;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            nxt_st = after_ff;
            nxt_cnt = 4'h0;
            nxt_drv = 1'b0;
            if (after_ff == ST_RD) begin
              nxt_sh = rd_byte;
              nxt_drv = ~rd_byte[7];
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_ff == LAST_RD_BIT) begin
              nxt_st = ST_RACK;
              nxt_drv = 1'b0;
              nxt_ptr = ptr_ff + 8'h01;
            end else begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_drv = ~sh_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            nxt_nack = sda_i;
          end else if (scl_fall) begin
            if (nack_ff) begin
              nxt_st = ST_IDLE;
            end else begin
              nxt_st = ST_RD;
              nxt_cnt = 4'h0;
              nxt_sh = rd_byte;
              nxt_drv = ~rd_byte[7];
            end
          end
        end
        ST_IDLE: begin
          nxt_drv = 1'b0;
        end
        default: begin
          nxt_st = ST_IDLE;
          nxt_drv = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      st_ff <= ST_IDLE;
      after_ff <= ST_IDLE;
      cnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      ptr_ff <= 8'h00;
      drv_ff <= 1'b0;
      nack_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      after_ff <= nxt_after;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      ptr_ff <= nxt_ptr;
      drv_ff <= nxt_drv;
      nack_ff <= nxt_nack;
      scl_q_ff <= scl_i;
      sda_q_ff <= sda_i;
    end
  end

  // Register bank
  always_comb begin
    nxt_key = key_ff;
    nxt_thr = thr_ff;
    nxt_mar = mar_ff;
    nxt_strap_done = 1'b1;
    // Straps are taken on the first edge after reset release, never inside reset
    if (!strap_done_ff && pin_strap_setting_i) begin
      nxt_thr = {phase_output_seven_strap_i, phase_output_five_strap_i,
                 phase_output_three_strap_i, phase_output_two_strap_i};
    end
    if (wr_stb) begin
      if (ptr_ff == KEY_OFF) begin
        nxt_key = sh_ff;
      end
      // Locked or gated writes simply fall through, keeping the stored value
      if (cfg_wr_ok) begin
        for (int i = 0; i < LVL_CNT; i++) begin
          if (lvl_hit(ptr_ff, THR_OFF, i)) begin
            nxt_thr[i] = sh_ff;
          end
        end
        for (int i = 0; i < MAR_CNT; i++) begin
          if (lvl_hit(ptr_ff, MAR_OFF, i)) begin
            nxt_mar[i] = sh_ff[2:0];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      key_ff <= KEY_RST;
      thr_ff <= THR_RST;
      mar_ff <= {MAR_CNT{MAR_RST}};
      strap_done_ff <= 1'b0;
    end else begin
      key_ff <= nxt_key;
      thr_ff <= nxt_thr;
      mar_ff <= nxt_mar;
      strap_done_ff <= nxt_strap_done;
    end
  end

  for (genvar g = 0; g < LVL_CNT; g++) begin : gen_lvl
    if (g < MAR_CNT) begin : gen_mar
      assign level_cfg_o[g].margin = mar_ff[g];
    end else begin : gen_fix
      assign level_cfg_o[g].margin = LVL4_MAR;
    end
    assign level_cfg_o[g].thr = thr_ff[g];
    cfglk_shed_points #(
      .LVL_IDX(g)
    ) u_pts (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .cfg_i(level_cfg_o[g]),
      .pts_o(pts[g])
    );
  end

  // Level tracker: climb past the next upper point, drop below the current lower point
  always_comb begin
    nxt_lvl = lvl_ff;
    if (lvl_ff < 3'(LVL_CNT) && {1'b0, load_sense_i} > pts[lvl_ff[1:0]].upper) begin
      nxt_lvl = lvl_ff + 3'h1;
    end else if (lvl_ff != 3'h0 && load_sense_i < pts[2'(lvl_ff - 3'h1)].lower) begin
      nxt_lvl = lvl_ff - 3'h1;
    end
    nxt_phases = {1'b0, phase_code_i[lvl_ff]} + 4'h1;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      lvl_ff <= LVL_RST;
      phases_ff <= PHASES_RST;
    end else begin
      lvl_ff <= nxt_lvl;
      phases_ff <= nxt_phases;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drv_ff;
  assign shed_points_o = pts;
  assign lock_active_o = locked;
  assign load_level_o = lvl_ff;
  assign active_phases_o = phases_ff;

endmodule

// >>> tb/cfglk_bank_monitor.sv
// Port checks for the lock and shed threshold bank, bound into cfglk_bank.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/10ps
module cfglk_bank_monitor (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sda_oe_o,
  input wire logic power_state_indicator_i,
  input wire logic psi_override_i,
  input wire logic [7:0] load_sense_i,
  input wire cfglk_pkg::cfglk_codes_t phase_code_i,
  input wire cfglk_pkg::cfglk_cfg_t level_cfg_o,
  input wire cfglk_pkg::cfglk_pts_t shed_points_o,
  input wire logic lock_active_o,
  input wire logic [2:0] load_level_o,
  input wire logic [3:0] active_phases_o
);
  import cfglk_pkg::*;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_lock_freeze: assert property ($past(lock_active_o) |-> $stable(level_cfg_o))
    else $error("config changed while locked");
  a_psi_blocks: assert property (
    (!power_state_indicator_i && !psi_override_i)[*3] |=> $stable(level_cfg_o))
    else $error("config changed with power state low");
  a_upper_point: assert property ($past(nrst_i) |-> shed_points_o[1].upper ==
    {1'b0, $past(level_cfg_o[1].thr)} + {6'h00, $past(level_cfg_o[1].margin)})
    else $error("upper point wrong");
  a_lower_point: assert property ($past(nrst_i) |-> shed_points_o[2].lower ==
    (($past(level_cfg_o[2].thr) < {5'h00, $past(level_cfg_o[2].margin)}) ? 8'h00 :
    $past(level_cfg_o[2].thr) - {5'h00, $past(level_cfg_o[2].margin)}))
    else $error("lower point wrong");
  a_lvl4_margin: assert property ($past(nrst_i) |-> level_cfg_o[3].margin == LVL4_MAR &&
    shed_points_o[3].upper == {1'b0, $past(level_cfg_o[3].thr)} + {6'h00, LVL4_MAR})
    else $error("level four margin wrong");
  a_phase_map: assert property ($past(nrst_i) |->
    active_phases_o == {1'b0, $past(phase_code_i[load_level_o])} + 4'h1)
    else $error("phase count wrong");
  a_level_up: assert property (load_level_o < 3'h4 &&
    {1'b0, load_sense_i} > shed_points_o[load_level_o].upper |=>
    load_level_o == $past(load_level_o) + 3'h1)
    else $error("level did not rise");
  a_level_down: assert property (load_level_o != 3'h0 &&
    !(load_level_o < 3'h4 && {1'b0, load_sense_i} > shed_points_o[load_level_o].upper) &&
    load_sense_i < shed_points_o[load_level_o - 3'h1].lower |=>
    load_level_o == $past(load_level_o) - 3'h1)
    else $error("level did not fall");
  a_reset_vals: assert property (!$past(nrst_i) |->
    !sda_oe_o && !lock_active_o && active_phases_o == PHASES_RST)
    else $error("reset values wrong");
endmodule
bind cfglk_bank cfglk_bank_monitor i_mon (.ref_clk_i, .nrst_i, .sda_oe_o,
  .power_state_indicator_i, .psi_override_i, .load_sense_i, .phase_code_i,
  .level_cfg_o, .shed_points_o, .lock_active_o, .load_level_o, .active_phases_o);

// >>> tb/cfglk_host.sv
// Two-wire bus master model; reports each byte's ack and read data.
// Assumes a pull-up on the data wire; sda_low_o pulls it low.
`timescale 1ns/10ps
module cfglk_host #(
  parameter int HP = 6
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o,
  output logic res_v_o,
  output logic [8:0] res_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    res_v_o = 1'b0;
    res_o = 9'h000;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic post(input logic [8:0] r);
    res_o <= r;
    res_v_o <= 1'b1;
    hw(1);
    res_v_o <= 1'b0;
  endtask
  // Also serves as repeated start: data released while the clock is low
  task automatic start();
    sda_low_o <= 1'b0;
    hw(HP);
    scl_o <= 1'b1;
    hw(HP);
    sda_low_o <= 1'b1;
    hw(HP);
    scl_o <= 1'b0;
  endtask
  task automatic bit_x(input logic b, output logic s);
    hw(HP);
    sda_low_o <= ~b;
    hw(HP);
    scl_o <= 1'b1;
    hw(HP);
    s = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(d[i], s);
    bit_x(1'b1, s);
    post({~s, 8'h00});
  endtask
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, s);
    post({1'b1, d});
  endtask
  task automatic stop();
    hw(HP);
    sda_low_o <= 1'b1;
    hw(HP);
    scl_o <= 1'b1;
    hw(HP);
    sda_low_o <= 1'b0;
    hw(HP);
  endtask
endmodule

// >>> tb/config_lock_and_shed_thresholds_tb.sv
// Bench for cfglk_bank: bus writes and reads against a shadow of the registers.
// Assumes cfglk_host as bus master and the bound port checker.
`timescale 1ns/10ps
module config_lock_and_shed_thresholds_tb;
  import cfglk_pkg::*;
  localparam logic [6:0] ADR = 7'h20;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic pg = 1'b1;
  logic power_state_indicator = 1'b1;
  logic ovr = 1'b0;
  logic pss = 1'b0;
  logic [3:0][7:0] strap = '0;
  logic [7:0] load = 8'h00;
  cfglk_codes_t codes = 15'h6B3;
  logic scl, sda_low, sda_oe, res_v;
  logic [8:0] res, ex;
  wire sda = ~(sda_low | sda_oe);
  logic [8:0] expq[$];
  logic [7:0] shadow[0:7];
  logic [31:0] seed = 32'h9ACE9E78;
  int mismatches = 0;
  int total_checks = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  cfglk_bank #(.DEV_ADDR(ADR)) i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .power_good_i(pg),
    .power_state_indicator_i(power_state_indicator), .psi_override_i(ovr), .pin_strap_setting_i(pss),
    .phase_output_two_strap_i(strap[0]), .phase_output_three_strap_i(strap[1]),
    .phase_output_five_strap_i(strap[2]), .phase_output_seven_strap_i(strap[3]),
    .load_sense_i(load), .phase_code_i(codes), .level_cfg_o(), .shed_points_o(),
    .lock_active_o(), .load_level_o(), .active_phases_o());
  cfglk_host i_host (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(sda_low), .res_v_o(res_v), .res_o(res));
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task automatic finish_test();
    if (expq.size() != 0) begin
      mismatches++;
      $display("[ERR] pending results expected 0 seen %0d", expq.size());
    end
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    if (res_v === 1'b1) begin
      ex = (expq.size() != 0) ? expq.pop_front() : 9'h1FF;
      total_checks++;
      if (ex !== res) begin
        mismatches++;
        $display("[ERR] bus byte expected %h seen %h", ex, res);
      end
    end
  end
  // Load ramps and wraps so the level tracker climbs and falls
  always @(posedge ref_clk_i) begin
    load <= load + 8'h03;
    if (load == 8'hFF) codes <= {codes[11:0], codes[14:12] + 3'h3};
  end
  task automatic init_shadow(input logic [3:0][7:0] t);
    shadow[0] = KEY_RST;
    for (int i = 1; i < 8; i++) shadow[i] = (i < 5) ? t[i-1] : {5'h00, MAR_RST};
  endtask
  task automatic xb(input logic [7:0] d, input logic a);
    expq.push_back({a, 8'h00});
    i_host.wbyte(d);
  endtask
  task automatic wr(input logic [7:0] r, input logic [7:0] v);
    if (pg && (r == 8'h00 || (r < 8'h08 && shadow[0] !== KEY_LOCK_VAL && (power_state_indicator || ovr))))
      shadow[r[2:0]] = (r > 8'h04) ? (v & 8'h07) : v;
    i_host.start();
    xb({ADR, 1'b0}, pg);
    xb(r, pg);
    xb(v, pg);
    i_host.stop();
  endtask
  task automatic chk(input logic [7:0] r);
    i_host.start();
    xb({ADR, 1'b0}, 1'b1);
    xb(r, 1'b1);
    i_host.start();
    xb({ADR, 1'b1}, 1'b1);
    expq.push_back({1'b1, (r < 8'h08) ? shadow[r[2:0]] : 8'h00});
    i_host.rbyte(1'b1);
    i_host.stop();
  endtask
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    mismatches++;
    finish_test();
  end
  initial begin
    init_shadow(THR_RST);
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int r = 0; r < 9; r++) chk(8'(r));
    for (int r = 1; r < 9; r++) begin
      wr(8'(r), rnd());
      chk(8'(r));
    end
    power_state_indicator <= 1'b0;
    // The shadow reads the new level, so let it land first
    @(posedge ref_clk_i);
    wr(8'h01, rnd());
    chk(8'h01);
    ovr <= 1'b1;
    @(posedge ref_clk_i);
    wr(8'h05, rnd());
    chk(8'h05);
    wr(8'h00, KEY_LOCK_VAL);
    wr(8'h02, rnd());
    chk(8'h00);
    chk(8'h02);
    wr(8'h00, 8'h5A);
    wr(8'h02, rnd());
    chk(8'h02);
    pg <= 1'b0;
    @(posedge ref_clk_i);
    wr(8'h03, rnd());
    pg <= 1'b1;
    chk(8'h03);
    pss <= 1'b1;
    strap <= {rnd(), rnd(), rnd(), rnd()};
    nrst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    init_shadow(strap);
    for (int r = 0; r < 8; r++) chk(8'(r));
    finish_test();
  end
endmodule
